//--- hdl/gqw_qualifier.v
// gpio input qualifier for one group of pins plus idle and standby wake logic
// assumes pins and wake sources synchronous to mclk; osc clock sampled as a level
`timescale 1ns/1ps
`include "gqw_defines.vh"

// How it works
// RL1 - a zero period field samples the pins on every system clock.
// RL2 - a nonzero period n takes one sample every 2n system clocks.
// RL3 - the period field is eight bits and takes every value 0 to 255.
// RL4 - one period setting in the group control register serves all eight pins.
// RL5 - a per-pin select bit picks three or six matching samples.
// RL6 - the window spans the sample period times one less than the sample count.
// RL7 - three samples give a window of two sample periods.
// RL8 - six samples give a window of five sample periods.
// RL9 - a level that does not hold over every sample is dropped, the old level kept.
// RL10 - an outside source must hold an unqualified level at least two clocks.
// RL11 - the same pulse minimum applies to the interrupt 2 conversion start input.
// RL12 - idle ends on any enabled interrupt, watchdog, external nmi or reset pin (with idle qualification on, only qualified pin 0 does).
// RL13 - an idle wake lasts two clocks bare, or five plus the window qualified; the code takes one clock bare, and the window plus two qualified.
// RL14 - execution resumes 20 clocks after wake, or 1050 with flash asleep.
// RL15 - the latency counts up to the first instruction after the idle one.
// RL16 - a standby wake must hold 2 plus the 6-bit field oscillator cycles.
module gqw_qualifier #(
    parameter PINS        = 8,
    parameter PRD_W       = 8,
    parameter SLOW_CYCLES = `GQW_RESUME_SLOW_NS / `GQW_CLK_NS
) (
    input  wire             mclk,            // system clock, 100 MHz
    input  wire             reset_n,         // async reset, active low
    input  wire             clkEn,           // freezes all state when low
    input  wire             psel,            // apb select
    input  wire             penable,         // apb access phase
    input  wire             pwrite,          // apb write
    input  wire [11:0]      paddr,           // apb byte address
    input  wire [31:0]      pwdata,          // apb write data
    output wire             pready,          // apb ready
    output reg  [31:0]      prdata,          // apb read data
    output wire             pslverr,         // apb error, unmapped address
    input  wire [PINS-1:0]  pinIn,           // raw pin levels
    output reg  [PINS-1:0]  pinQual,         // qualified pin levels
    input  wire             irqWake,         // any enabled interrupt
    input  wire             watchdogIrq,     // watchdog interrupt
    input  wire             extNmiInput,     // external nmi
    input  wire             extResetPin_n,   // external reset pin, low active
    input  wire             oscInputClock,   // oscillator clock level
    input  wire             flashAsleep,     // flash in sleep state
    output reg              lowPowerExit,    // pulse, wake accepted
    output reg              resumeExec       // pulse, next instruction may start
);
    reg  [PRD_W-1:0] qualPeriodDiv_q;        // pin_group_ctrl
    reg  [PINS-1:0]  qualSampleSelect_q;     // 1 = six samples
    reg  [1:0]       lpMode_q;
    reg  [5:0]       standbyWakeQual_q;
    reg              stbyQualEn_q;
    reg              idleQualEn_q;
    reg  [PRD_W:0]   divCnt_q;
    reg              sampleTick;
    reg  [6:0]       oscHighCnt_q;
    reg              oscPrev_q;
    reg              wakeIdle_q;
    reg              wakeStby_q;
    reg              resumeBusy_q;
    reg  [13:0]      resumeCnt_q;
    wire             apbWr;
    wire             addrOk;
    wire             idleSrc;
    wire             idleSrcQ;
    wire             oscRise;
    wire [6:0]       stbyNeed;
    wire [13:0]      fastCycles;
    wire [13:0]      slowCycles;
    wire             selCtrl;
    wire             selQsel;
    wire             selLpm;
    wire             selData;
    wire             selWake;
    wire             idleHit;
    wire             stbyHit;

    localparam [31:0] FAST_CYCLES = `GQW_RESUME_FAST_NS / `GQW_CLK_NS;

    // one-hot register decode
    assign selCtrl    = (paddr == `GQW_OFF_CTRL);
    assign selQsel    = (paddr == `GQW_OFF_QSEL);
    assign selLpm     = (paddr == `GQW_OFF_LPM);
    assign selData    = (paddr == `GQW_OFF_DATA);
    assign selWake    = (paddr == `GQW_OFF_WAKE);
    assign pready     = 1'b1;
    assign apbWr      = psel & penable & pwrite & clkEn;
    assign addrOk     = selCtrl | selQsel | selLpm | selData | selWake;
    assign pslverr    = psel & penable & ~addrOk;
    assign fastCycles = FAST_CYCLES[13:0];
    assign slowCycles = SLOW_CYCLES[13:0];

    // register writes
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            qualPeriodDiv_q    <= {PRD_W{1'b0}};
            qualSampleSelect_q <= {PINS{1'b0}};
            standbyWakeQual_q  <= 6'h00;
            stbyQualEn_q       <= 1'b0;
            idleQualEn_q       <= 1'b0;
        end else if (apbWr && addrOk) begin
            case (paddr)
                `GQW_OFF_CTRL: begin
                    qualPeriodDiv_q <= pwdata[`GQW_PRD_MSB:`GQW_PRD_LSB]; // [RL3] [RL4]
                end
                `GQW_OFF_QSEL: begin
                    qualSampleSelect_q <= pwdata[PINS-1:0];               // [RL5]
                end
                `GQW_OFF_LPM: begin
                    standbyWakeQual_q <= pwdata[`GQW_SQ_MSB:`GQW_SQ_LSB]; // [RL16]
                    stbyQualEn_q      <= pwdata[`GQW_SQ_EN_BIT];
                    idleQualEn_q      <= pwdata[`GQW_IDLE_EN_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // low power mode, forced back to run on wake and while resuming
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lpMode_q <= `GQW_MODE_RUN;
        end else if (clkEn) begin
            if (apbWr && selLpm) begin
                lpMode_q <= pwdata[`GQW_LPM_MODE_MSB:`GQW_LPM_MODE_LSB];
            end else if (lowPowerExit || resumeBusy_q) begin
                lpMode_q <= `GQW_MODE_RUN;
            end
        end
    end

    // read mux
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h00000000;
        end else if (clkEn && psel && !penable && !pwrite) begin
            prdata <= 32'h00000000;
            case (paddr)
                `GQW_OFF_CTRL: begin
                    prdata[PRD_W-1:0] <= qualPeriodDiv_q;
                end
                `GQW_OFF_QSEL: begin
                    prdata[PINS-1:0] <= qualSampleSelect_q;
                end
                `GQW_OFF_LPM: begin
                    prdata[`GQW_LPM_MODE_MSB:`GQW_LPM_MODE_LSB] <= lpMode_q;
                    prdata[`GQW_SQ_MSB:`GQW_SQ_LSB]             <= standbyWakeQual_q;
                    prdata[`GQW_SQ_EN_BIT]                      <= stbyQualEn_q;
                    prdata[`GQW_IDLE_EN_BIT]                    <= idleQualEn_q;
                end
                `GQW_OFF_DATA: begin
                    prdata[PINS-1:0] <= pinQual;
                end
                `GQW_OFF_WAKE: begin
                    prdata[`GQW_WS_IDLE_BIT] <= wakeIdle_q;
                    prdata[`GQW_WS_STBY_BIT] <= wakeStby_q;
                    prdata[`GQW_WS_BUSY_BIT] <= resumeBusy_q;
                end
                default: begin
                    prdata <= 32'h00000000;
                end
            endcase
        end
    end

    // shared sample divider: period 1 when field is zero, else 2n
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            divCnt_q   <= {(PRD_W+1){1'b0}};
            sampleTick <= 1'b0;
        end else if (clkEn) begin
            if (qualPeriodDiv_q == {PRD_W{1'b0}}) begin
                divCnt_q   <= {(PRD_W+1){1'b0}};
                sampleTick <= 1'b1;                                    // [RL1]
            end else if (divCnt_q >= {qualPeriodDiv_q, 1'b0} - 1'b1) begin
                divCnt_q   <= {(PRD_W+1){1'b0}};
                sampleTick <= 1'b1;                                    // [RL2]
            end else begin
                divCnt_q   <= divCnt_q + 1'b1;
                sampleTick <= 1'b0;
            end
        end
    end

    // per-pin qualifier: a new level must match on count+1 samples
    genvar g;
    generate
        for (g = 0; g < PINS; g = g + 1) begin : pinQ
            reg       lastSmp_q;
            reg [2:0] matchCnt_q;
            wire [2:0] need;
            assign need = qualSampleSelect_q[g] ? `GQW_CNT6 : `GQW_CNT3; // [RL5] [RL6]
            always @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    lastSmp_q  <= 1'b0;
                    matchCnt_q <= 3'h0;
                    pinQual[g] <= 1'b0;
                end else if (clkEn && sampleTick) begin
                    lastSmp_q <= pinIn[g];
                    if (pinIn[g] != lastSmp_q || pinIn[g] == pinQual[g]) begin
                        matchCnt_q <= 3'h0;                           // [RL9]
                    end else if (matchCnt_q + 1'b1 >= need) begin
                        pinQual[g] <= pinIn[g];                       // [RL7] [RL8]
                        matchCnt_q <= 3'h0;
                    end else begin
                        matchCnt_q <= matchCnt_q + 1'b1;
                    end
                end
            end
        end
    endgenerate

    // idle wake sources; pin 0 qualified path is the wake input when enabled
    assign idleSrc  = irqWake | watchdogIrq | extNmiInput | ~extResetPin_n;   // [RL12]
    assign idleSrcQ = idleQualEn_q ? pinQual[0] : idleSrc;                    // [RL13]

    // standby: count oscillator high-going edges while wake pin holds high
    assign oscRise  = oscInputClock & ~oscPrev_q;
    assign stbyNeed = stbyQualEn_q ? (`GQW_STBY_BASE + {1'b0, standbyWakeQual_q})
                                   : `GQW_STBY_MIN;                          // [RL16]
    assign idleHit  = (lpMode_q == `GQW_MODE_IDLE) & idleSrcQ & ~lowPowerExit;  // [RL12]
    assign stbyHit  = (lpMode_q == `GQW_MODE_STBY) & (oscHighCnt_q >= stbyNeed)
                      & ~lowPowerExit;                                          // [RL16]

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            oscPrev_q    <= 1'b0;
            oscHighCnt_q <= 7'h00;
        end else if (clkEn) begin
            oscPrev_q <= oscInputClock;
            if (lpMode_q != `GQW_MODE_STBY || !pinIn[0]) begin
                oscHighCnt_q <= 7'h00;
            end else if (oscRise && oscHighCnt_q != 7'h7f) begin
                oscHighCnt_q <= oscHighCnt_q + 1'b1;
            end
        end
    end

    // one-cycle exit pulse
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lowPowerExit <= 1'b0;
        end else if (clkEn) begin
            lowPowerExit <= idleHit | stbyHit;
        end
    end

    // wake status, write one to clear; a new wake beats the clear
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wakeIdle_q <= 1'b0;
            wakeStby_q <= 1'b0;
        end else if (clkEn) begin
            if (idleHit) begin
                wakeIdle_q <= 1'b1;
            end else if (apbWr && selWake && pwdata[`GQW_WS_IDLE_BIT]) begin
                wakeIdle_q <= 1'b0;
            end
            if (stbyHit) begin
                wakeStby_q <= 1'b1;
            end else if (apbWr && selWake && pwdata[`GQW_WS_STBY_BIT]) begin
                wakeStby_q <= 1'b0;
            end
        end
    end

    // resume latency counter up to the instruction after idle
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            resumeBusy_q <= 1'b0;
            resumeCnt_q  <= 14'h0000;
            resumeExec   <= 1'b0;
        end else if (clkEn) begin
            resumeExec <= 1'b0;
            if (lowPowerExit) begin
                resumeBusy_q <= 1'b1;
                // exit pulse cycle counts as the first of the latency
                resumeCnt_q  <= (flashAsleep ? slowCycles : fastCycles) - 14'h0001; // [RL14]
            end else if (resumeBusy_q) begin
                if (resumeCnt_q <= 14'h0001) begin
                    resumeBusy_q <= 1'b0;
                    resumeExec   <= 1'b1;                            // [RL15]
                end else begin
                    resumeCnt_q <= resumeCnt_q - 1'b1;
                end
            end
        end
    end
endmodule

//--- hdl/gqw_defines.vh
// constants for the gpio input qualifier and wake block
// assumes inclusion by bare name from hdl/
`ifndef GQW_DEFINES_VH
`define GQW_DEFINES_VH
// apb register byte offsets
`define GQW_OFF_CTRL      12'h000
`define GQW_OFF_QSEL      12'h004
`define GQW_OFF_LPM       12'h008
`define GQW_OFF_DATA      12'h00c
`define GQW_OFF_WAKE      12'h010
// pin_group_ctrl fields
`define GQW_PRD_LSB       0
`define GQW_PRD_MSB       7
// lowpower_ctrl_reg fields
`define GQW_LPM_MODE_LSB  0
`define GQW_LPM_MODE_MSB  1
`define GQW_SQ_LSB        2
`define GQW_SQ_MSB        7
`define GQW_SQ_EN_BIT     8
`define GQW_IDLE_EN_BIT   9
// wake status bits
`define GQW_WS_IDLE_BIT   0
`define GQW_WS_STBY_BIT   1
`define GQW_WS_BUSY_BIT   2
// low power modes
`define GQW_MODE_RUN      2'h0
`define GQW_MODE_IDLE     2'h1
`define GQW_MODE_STBY     2'h2
// match thresholds, one less than the sample count
`define GQW_CNT3          3'h2
`define GQW_CNT6          3'h5
// unqualified standby minimum and qualified base in oscillator cycles
`define GQW_STBY_MIN      7'h03
`define GQW_STBY_BASE     7'h02
// resume latencies and system clock period in nanoseconds
`define GQW_RESUME_FAST_NS   200
`define GQW_RESUME_SLOW_NS   10500
`define GQW_CLK_NS           10
`endif

//--- tb/gqw_pin_source.sv
// far-side model: pin drivers, wake sources, free running oscillator
// assumes the bench calls its tasks just after a rising mclk edge
`timescale 1ns/1ps
module gqw_pin_source (
    input  wire       mclk,          // system clock
    output reg  [7:0] pinIn,         // pin levels
    output reg        oscInputClock, // oscillator level, mclk / 4
    output reg  [3:0] wake           // irq, watchdog, nmi, reset pin
);
    reg [1:0] div_q = 2'h0;
    initial begin
        pinIn = 8'h00;
        oscInputClock = 1'b0;
        wake = 4'h0;
    end
    always @(posedge mclk) begin
        div_q <= div_q + 2'h1;
        oscInputClock <= div_q[1];
    end
    task drive(input [7:0] lvl);
        pinIn <= lvl; // levels held whole clocks
    endtask
    task raise(input [3:0] src);
        begin
            wake <= src;
            fork
                begin
                    repeat (3) @(posedge mclk);
                    wake <= 4'h0; // wake held three clocks
                end
            join_none
        end
    endtask
endmodule

//--- tb/gqw_qualifier_properties.sv
// port checker for the qualifier block
// assumes register offsets of gqw_defines.vh; checks pause while clkEn is low
`timescale 1ns/1ps
module gqw_qualifier_properties #(
    parameter PINS        = 8,
    parameter SLOW_CYCLES = 1050
) (
    input wire            mclk, reset_n, clkEn,          // clock, reset, enable
    input wire            psel, penable, pwrite, pready, // apb controls
    input wire            pslverr,                       // apb error
    input wire [11:0]     paddr,                         // apb address
    input wire [31:0]     pwdata,                        // apb write data
    input wire [PINS-1:0] pinIn, pinQual,                // raw, qualified pins
    input wire            irqWake, watchdogIrq,          // wake sources
    input wire            extNmiInput, extResetPin_n,    // wake sources
    input wire            oscInputClock, flashAsleep,    // standby clock, flash
    input wire            lowPowerExit, resumeExec       // wake, resume pulses
);
    localparam [11:0] SLOW12 = SLOW_CYCLES;
    wire wr = psel && penable && pwrite && clkEn;
    wire src = irqWake || watchdogIrq || extNmiInput || !extResetPin_n;
    reg [7:0] prd_q;
    reg [PINS-1:0] qsel_q;
    reg [1:0] mode_q;
    reg [6:0] need_q, osc_q;
    reg [11:0] wait_q;
    reg slow_q, oscP_q;
    wire [11:0] resNeed = slow_q ? SLOW12 : 12'h014;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            {prd_q, qsel_q, mode_q, osc_q, wait_q, slow_q, oscP_q} <= 0;
            need_q <= 7'h03;
        end else if (clkEn) begin
            if (wr && paddr == 12'h000) prd_q <= pwdata[7:0];
            if (wr && paddr == 12'h004) qsel_q <= pwdata[PINS-1:0];
            if (wr && paddr == 12'h008) begin
                mode_q <= pwdata[1:0];
                need_q <= pwdata[8] ? 7'h02 + {1'b0, pwdata[7:2]} : 7'h03;
            end else if (lowPowerExit || (mode_q == 2'h1 && src)) mode_q <= 2'h0;
            oscP_q <= oscInputClock;
            osc_q <= !pinIn[0] ? 7'h00 : osc_q + {6'h00, oscInputClock && !oscP_q};
            wait_q <= lowPowerExit ? 12'h001 :
                      (resumeExec || wait_q == 12'h000) ? 12'h000 : wait_q + 12'h001;
            if (lowPowerExit) slow_q <= flashAsleep;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n || !clkEn);
    a_zero_wait: assert property (psel |-> pready) else $error("pready low");
    a_bad_addr: assert property (psel && penable |->
        pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010}))
        else $error("pslverr wrong for address");
    a_qual_hold: assert property (prd_q == 8'h00 && $changed(pinQual) |->
        ((($past(pinIn, 3) ^ pinQual) & (pinQual ^ $past(pinQual))) == 0))
        else $error("pin qualified without held level");
    a_six_hold: assert property (prd_q == 8'h00 && $changed(pinQual) |->
        ((($past(pinIn, 6) ^ pinQual) & (pinQual ^ $past(pinQual)) & qsel_q) == 0))
        else $error("six sample pin qualified early");
    a_follow_three: assert property (prd_q == 8'h00 && $stable(pinIn) [*6] |->
        ((pinIn ^ pinQual) & ~qsel_q) == 0) else $error("three sample pin late");
    a_follow_six: assert property (prd_q == 8'h00 && $stable(pinIn) [*8] |->
        pinQual == pinIn) else $error("six sample pin late");
    a_idle_exit: assert property (mode_q == 2'h1 && src |=> lowPowerExit)
        else $error("idle wake missed");
    a_exit_cause: assert property (lowPowerExit |-> $past(mode_q) != 2'h0)
        else $error("exit outside low power");
    a_resume_time: assert property (resumeExec |-> wait_q == resNeed)
        else $error("resume at wrong time");
    a_resume_due: assert property (wait_q == resNeed |-> resumeExec)
        else $error("resume missing");
    a_stby_min: assert property (lowPowerExit && $past(mode_q) == 2'h2 |->
        osc_q >= need_q - 7'h01) else $error("standby exit too early");
    c_idle: cover property (mode_q == 2'h1 && src);
    c_stby: cover property (lowPowerExit && $past(mode_q) == 2'h2);
    c_slow: cover property (resumeExec && slow_q);
endmodule
bind gqw_qualifier gqw_qualifier_properties #(.PINS(PINS), .SLOW_CYCLES(SLOW_CYCLES))
    u_props (.mclk, .reset_n, .clkEn, .psel, .penable, .pwrite, .pready, .pslverr,
    .paddr, .pwdata, .pinIn, .pinQual, .irqWake, .watchdogIrq, .extNmiInput,
    .extResetPin_n, .oscInputClock, .flashAsleep, .lowPowerExit, .resumeExec);

//--- tb/gqw_qualifier_test.sv
// self-checking bench for the qualifier block
// assumes the pin source model and the bound checker
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module gqw_qualifier_test;
    localparam SLOW = 30;
    reg         mclk = 1'b0, reset_n = 1'b0, clkEn = 1'b1, flashAsleep = 1'b0;
    reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0, rd;
    wire        pready, pslverr, lowPowerExit, resumeExec, oscInputClock;
    wire [31:0] prdata;
    wire [7:0]  pinIn, pinQual;
    wire [3:0]  wake;
    wire        irqWake = wake[0], watchdogIrq = wake[1], extNmiInput = wake[2];
    wire        extResetPin_n = !wake[3];
    integer     miscompares = 0, compares = 0, n, i;
    always #5 mclk = ~mclk;
    gqw_qualifier #(.SLOW_CYCLES(SLOW)) u_gqw_qualifier (.mclk, .reset_n, .clkEn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .pinIn, .pinQual,
        .irqWake, .watchdogIrq, .extNmiInput, .extResetPin_n, .oscInputClock,
        .flashAsleep, .lowPowerExit, .resumeExec);
    gqw_pin_source u_gqw_pin_source (.mclk, .pinIn, .oscInputClock, .wake);
    task close_out;
        begin
            $display("compares %0d miscompares %0d", compares, miscompares);
            if (miscompares == 0 && compares > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    task automatic apb(input [11:0] a, input w, input [31:0] d);
        integer k;
        begin
            psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
            @(posedge mclk) penable <= 1'b1;
            k = 0;
            do begin @(posedge mclk); k++; end while (pready !== 1'b1 && k < 16);
            rd = prdata; err = pslverr;
            psel <= 1'b0; penable <= 1'b0;
            @(posedge mclk);
            if (k >= 16) begin miscompares++; close_out; end
        end
    endtask
    task automatic until_q(input [7:0] v, input integer lim, output integer c);
        begin
            c = 0;
            do begin @(posedge mclk); #1; c++; end while (pinQual !== v && c < lim);
            if (c >= lim) begin miscompares++; close_out; end
        end
    endtask
    task automatic until_w(input sel, input integer lim, output integer c);
        begin
            c = 0;
            do begin @(posedge mclk); #1; c++; end
            while ((sel ? resumeExec : lowPowerExit) !== 1'b1 && c < lim);
            if (c >= lim) begin miscompares++; close_out; end
        end
    endtask
    task automatic t_regs;
        begin
            apb(12'h000, 1'b1, 32'hffff_ffff);
            apb(12'h000, 1'b0, 32'h0);
            `CHK(rd, 32'h0000_00ff)
            apb(12'h020, 1'b0, 32'h0);
            `CHK({err, rd}, 33'h1_0000_0000)
            $display("test regs done");
        end
    endtask
    task automatic t_qual(input [7:0] prd, sel, lvl, input integer lo, hi);
        begin
            apb(12'h000, 1'b1, {24'h0, prd});
            apb(12'h004, 1'b1, {24'h0, sel});
            u_gqw_pin_source.drive(lvl);
            until_q(lvl, 2000, n);
            `CHK(n >= lo && n <= hi, 1'b1)
            u_gqw_pin_source.drive(8'h00);
            until_q(8'h00, 2000, n);
            $display("test qual prd %h sel %h done", prd, sel);
        end
    endtask
    task automatic t_mix;
        begin
            apb(12'h000, 1'b1, 32'h0);
            apb(12'h004, 1'b1, 32'h0f);
            u_gqw_pin_source.drive(8'hff);
            repeat (4) @(posedge mclk);
            #1 `CHK(pinQual, 8'hf0)
            repeat (3) @(posedge mclk);
            #1 `CHK(pinQual, 8'hff)
            u_gqw_pin_source.drive(8'h00);
            until_q(8'h00, 20, n);
            $display("test mixed select done");
        end
    endtask
    task automatic t_glitch(input [7:0] sel, input integer len);
        begin
            apb(12'h004, 1'b1, {24'h0, sel});
            u_gqw_pin_source.drive(8'h81);
            repeat (len) @(posedge mclk);
            u_gqw_pin_source.drive(8'h00);
            repeat (10) @(posedge mclk);
            #1 `CHK(pinQual, 8'h00)
            $display("test glitch %0d done", len);
        end
    endtask
    task automatic t_idle(input [3:0] src, input flash);
        begin
            flashAsleep <= flash;
            apb(12'h008, 1'b1, 32'h1);
            u_gqw_pin_source.raise(src);
            until_w(1'b0, 8, n);
            `CHK(n, 1)
            until_w(1'b1, 2000, n);
            `CHK(n, flash ? SLOW : 20)
            $display("test idle source %h done", src);
        end
    endtask
    task automatic t_stby(input [31:0] cfg, input integer need);
        begin
            apb(12'h008, 1'b1, cfg);
            u_gqw_pin_source.drive(8'h01);
            until_w(1'b0, 400, n);
            `CHK(n >= 4 * need - 4 && n <= 4 * need + 4, 1'b1)
            u_gqw_pin_source.drive(8'h00);
            until_w(1'b1, 40, n);
            $display("test standby need %0d done", need);
        end
    endtask
    task automatic t_freeze;
        begin
            clkEn <= 1'b0;
            u_gqw_pin_source.drive(8'hff);
            repeat (10) @(posedge mclk);
            #1 `CHK(pinQual, 8'h00)
            @(posedge mclk) clkEn <= 1'b1;
            until_q(8'hff, 20, n);
            `CHK(n, 6)
            u_gqw_pin_source.drive(8'h00);
            until_q(8'h00, 20, n);
            $display("test clock enable freeze done");
        end
    endtask
    task automatic t_idle_q;
        begin
            apb(12'h008, 1'b1, 32'h201);
            u_gqw_pin_source.drive(8'h01);
            until_w(1'b0, 20, n);
            `CHK(n, 7)
            until_w(1'b1, 40, n);
            `CHK(n, 20)
            u_gqw_pin_source.drive(8'h00);
            until_q(8'h00, 20, n);
            $display("test qualified idle done");
        end
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        t_regs;
        t_qual(8'h00, 8'h00, 8'hff, 3, 3);
        t_qual(8'h00, 8'hff, 8'h5a, 6, 6);
        t_qual(8'h01, 8'h00, 8'h81, 5, 6);
        t_qual(8'h02, 8'hff, 8'h3c, 21, 24);
        t_qual(8'hff, 8'h00, 8'h01, 1021, 1530);
        t_mix;
        t_glitch(8'h00, 2);
        t_glitch(8'hff, 5);
        t_freeze;
        t_idle_q;
        for (i = 0; i < 4; i++) t_idle(4'h1 << i, i == 3);
        flashAsleep <= 1'b0;
        t_stby(32'h2, 3);
        t_stby(32'h10e, 5);
        t_stby(32'h1fe, 65);
        close_out;
    end
endmodule
